// [hw/channel_drive_seq.sv]
// module: per-channel activation, excitation/sustain sequencing and output decode
`timescale 1ns/1ps
module channel_drive_seq (
  // clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      nrst_i,
  // channel setup
  input  wire solenoid_regs_pkg::cfg_t   cfg_i,
  // activation and timing inputs
  input  wire logic                      serial_channel_on_bit_i,
  input  wire logic                      external_trigger_pin_i,
  input  wire logic                      base_chop_tick_i,
  // drive controls
  output solenoid_regs_pkg::drive_t      drive_o
);

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_EXCITE,
    PH_HOLD
  } phase_t;

  typedef struct packed {
    phase_t                    phase;
    logic [1:0]                pre;
    logic [5:0]                sub;
    logic [7:0]                units;
    solenoid_regs_pkg::drive_t drv;
  } seq_state_t;

  seq_state_t st_r;
  seq_state_t st_nxt;

  logic       act;
  logic [1:0] term;
  logic       tick;
  logic       high;
  logic [6:0] lvl;

  // next-state logic
  always_comb
  begin
    st_nxt = st_r;
    act    = cfg_i.activation_source_sel ? external_trigger_pin_i
                                         : serial_channel_on_bit_i; // R3
    term   = 2'(solenoid_regs_pkg::CHOP_DIV_MAX_TERM - cfg_i.chop_divider_sel); // R8
    tick   = base_chop_tick_i && (st_r.pre >= term);
    if (base_chop_tick_i)
    begin
      st_nxt.pre = tick ? 2'h0 : 2'(st_r.pre + 2'h1);
    end
    // excitation timing in units of 40 chopping periods
    if (!act)
    begin
      st_nxt.phase = PH_IDLE;
    end
    else
    begin
      case (st_r.phase)
        PH_IDLE:
        begin
          st_nxt.sub   = 6'h00;
          st_nxt.units = cfg_i.excite_time;
          st_nxt.phase = (cfg_i.excite_time == solenoid_regs_pkg::HIT_T_NONE) ? PH_HOLD
                                                                               : PH_EXCITE; // R5
        end
        PH_EXCITE:
        begin
          if (tick && cfg_i.excite_time != solenoid_regs_pkg::HIT_T_CONT) // R5
          begin
            if (st_r.sub == 6'(solenoid_regs_pkg::CHOP_PER_UNIT - 6'h01))
            begin
              st_nxt.sub = 6'h00;
              if (st_r.units <= 8'h01)
              begin
                st_nxt.phase = PH_HOLD;
              end
              else
              begin
                st_nxt.units = 8'(st_r.units - 8'h01);
              end
            end
            else
            begin
              st_nxt.sub = 6'(st_r.sub + 6'h01);
            end
          end
        end
        default:
        begin
          st_nxt.phase = PH_HOLD;
        end
      endcase
    end
    // output decode from the new phase
    high = cfg_i.regulation_method_sel & cfg_i.side_sel; // R7
    lvl  = (st_nxt.phase == PH_EXCITE) ? cfg_i.excite_level : cfg_i.hold_level; // R2 R4
    st_nxt.drv.active       = (st_nxt.phase != PH_IDLE);
    st_nxt.drv.excite_phase = (st_nxt.phase == PH_EXCITE);
    st_nxt.drv.high_side    = high;
    st_nxt.drv.level        = lvl;
    st_nxt.drv.half_scale   = cfg_i.half_scale_sel;                    // R1
    st_nxt.drv.current_reg  = ~cfg_i.regulation_method_sel;           // R6
    st_nxt.drv.slew_en      = cfg_i.slew_limit_en & ~high;            // R9
    st_nxt.drv.chop_tick    = tick;
    st_nxt.drv.ol_run       = cfg_i.open_load_check_en;               // R10
    st_nxt.drv.plunger_run  = cfg_i.plunger_check_en & (st_nxt.phase != PH_IDLE); // R11
    st_nxt.drv.excite_chk_run = cfg_i.excite_check_en & ~cfg_i.regulation_method_sel
                                & (st_nxt.phase == PH_EXCITE);       // R12 R19
    if (st_nxt.phase == PH_IDLE || lvl == solenoid_regs_pkg::LEVEL_OFF)
    begin
      st_nxt.drv.hs_gate = ~high; // inactive rail per side, R2 R4
      st_nxt.drv.ls_gate = high;
      st_nxt.drv.reg_en  = 1'b0;
    end
    else if (lvl == solenoid_regs_pkg::LEVEL_FULL)
    begin
      st_nxt.drv.hs_gate = high;  // fully on per side, R2 R4
      st_nxt.drv.ls_gate = ~high;
      st_nxt.drv.reg_en  = 1'b0;
    end
    else
    begin
      st_nxt.drv.hs_gate = 1'b0;  // regulated duty cycle or current
      st_nxt.drv.ls_gate = 1'b0;
      st_nxt.drv.reg_en  = 1'b1;
    end
  end

  // state register
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign drive_o = st_r.drv;

endmodule // channel_drive_seq

// [hw/solenoid_channel_config_fault_regs.sv]
// module: channel setup words and clear-on-read fault flags of the eight-channel driver
//
// Behaviour
// R1: setup bit 31 picks full scale when 0, half scale when 1.
// R2: sustain level bits 30:24: 0 off, 127 fully on, else regulated.
// R3: bit 23 picks serial on-bit (0) or external trigger pin (1).
// R4: excitation level bits 22:16 decode like the sustain level.
// R5: bits 15:8 excitation time: 0 none, 1-254 times 40 chops, 255 continuous.
// R6: bit 7: 0 current regulation, 1 voltage regulation.
// R7: bit 6 high side only under voltage regulation; current regulation is low side.
// R8: bits 5:4 divide base chopping frequency by 4, 3, 2 or 1.
// R9: bit 3 enables slew-limited transitions in low-side mode.
// R10: bit 2 enables the open-load check; clear means never run.
// R11: bit 1 enables the plunger-movement check; clear means never run.
// R12: bit 0 enables the excitation-current-reached check.
// R13: reading the fault register at 0x09 clears all its flags.
// R14: fault bits 31:24 are per-channel overcurrent flags.
// R15: fault bits 23:16 flag excitation current not reached.
// R16: fault bits 15:8 are per-channel open-load flags.
// R17: fault bits 7:0 are per-channel plunger-movement flags.
// R18: setup words sit at addresses 0x01 to 0x08, one per channel.
// R19: missed excitation current is flagged only under current regulation.
// R20: bit n of each fault field belongs to channel n.
`timescale 1ns/1ps
module solenoid_channel_config_fault_regs #(
  parameter int unsigned NUM_CH = 8
) (
  // clock and reset
  input  wire logic                                 sys_clk_i,
  input  wire logic                                 nrst_i,
  // register access port
  input  wire logic [solenoid_regs_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic                                 reg_wr_i,
  input  wire logic                                 reg_rd_i,
  input  wire logic [31:0]                          reg_wdata_i,
  output logic      [31:0]                          reg_rdata_o,
  output logic                                      reg_rvalid_o,
  // channel activation and chopping time base
  input  wire logic [NUM_CH-1:0]                    serial_channel_on_bit_i,
  input  wire logic [NUM_CH-1:0]                    external_trigger_pin_i,
  input  wire logic                                 base_chop_tick_i,
  // raw fault events from the output stages
  input  wire solenoid_regs_pkg::fault_t            fault_evt_i,
  // drive controls per channel
  output solenoid_regs_pkg::drive_t [NUM_CH-1:0]    drive_o
);

  // fault fields are one byte wide, so the channel count is fixed
  if (NUM_CH != 8)
  begin : g_bad_ch
    $error("NUM_CH must be 8 to match the fault register layout");
  end

  typedef struct packed {
    solenoid_regs_pkg::cfg_t [NUM_CH-1:0] cfg;
    solenoid_regs_pkg::fault_t            flags;
    logic [31:0]                          rdata;
    logic                                 rvalid;
  } regs_state_t;

  regs_state_t st_r;
  regs_state_t st_nxt;

  // per-channel qualified fault sets and helper vectors
  logic [NUM_CH-1:0] set_ocp;
  logic [NUM_CH-1:0] set_miss;
  logic [NUM_CH-1:0] set_ol;
  logic [NUM_CH-1:0] set_dpm;
  logic [NUM_CH-1:0] miss_ok_vec;
  logic [NUM_CH-1:0] open_load_check_en_vec;
  logic [NUM_CH-1:0] plunger_check_en_vec;
  logic [NUM_CH-1:0] cur_vec;
  logic [NUM_CH-1:0] hi_vec;

  logic in_cfg;
  logic rd_fault;

  // address decode
  assign in_cfg   = (reg_addr_i >= solenoid_regs_pkg::ADDR_CFG_FIRST)
                 && (reg_addr_i <= solenoid_regs_pkg::ADDR_CFG_LAST);   // R18
  assign rd_fault = reg_rd_i && (reg_addr_i == solenoid_regs_pkg::ADDR_FAULT);

  // per-channel sequencers and fault qualification
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    channel_drive_seq u_seq (
      .sys_clk_i               (sys_clk_i),
      .nrst_i                  (nrst_i),
      .cfg_i                   (st_r.cfg[i]),
      .serial_channel_on_bit_i (serial_channel_on_bit_i[i]),
      .external_trigger_pin_i  (external_trigger_pin_i[i]),
      .base_chop_tick_i        (base_chop_tick_i),
      .drive_o                 (drive_o[i])
    );
    assign miss_ok_vec[i] = st_r.cfg[i].excite_check_en
                          & ~st_r.cfg[i].regulation_method_sel;           // R12 R19
    assign open_load_check_en_vec[i]   = st_r.cfg[i].open_load_check_en;
    assign plunger_check_en_vec[i]  = st_r.cfg[i].plunger_check_en;
    assign cur_vec[i]     = ~st_r.cfg[i].regulation_method_sel;
    assign hi_vec[i]      = drive_o[i].high_side;
    assign set_ocp[i]     = fault_evt_i.overcurrent_flags[i];             // R14 R20
    assign set_miss[i]    = fault_evt_i.excite_miss_flags[i] & miss_ok_vec[i]; // R15 R19
    assign set_ol[i]      = fault_evt_i.open_load_flags[i] & open_load_check_en_vec[i];     // R10 R16
    assign set_dpm[i]     = fault_evt_i.plunger_motion_flags[i] & plunger_check_en_vec[i]; // R11 R17
  end

  // register next-state logic
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.rvalid = reg_rd_i;
    // read data: unmapped addresses read as zero
    if (!reg_rd_i)
    begin
      st_nxt.rdata = st_r.rdata;
    end
    else if (in_cfg)
    begin
      st_nxt.rdata = st_r.cfg[3'(reg_addr_i - solenoid_regs_pkg::ADDR_CFG_FIRST)]; // R18
    end
    else if (reg_addr_i == solenoid_regs_pkg::ADDR_FAULT)
    begin
      st_nxt.rdata = st_r.flags; // R13
    end
    else
    begin
      st_nxt.rdata = solenoid_regs_pkg::RDATA_RST;
    end
    // setup word writes; writes to the fault register are ignored
    if (reg_wr_i && in_cfg)
    begin
      st_nxt.cfg[3'(reg_addr_i - solenoid_regs_pkg::ADDR_CFG_FIRST)] = reg_wdata_i; // R18
    end
    // clear on read, with a same-cycle event winning over the clear
    if (rd_fault)
    begin
      st_nxt.flags = solenoid_regs_pkg::FAULT_RST; // R13
    end
    st_nxt.flags.overcurrent_flags    = st_nxt.flags.overcurrent_flags | set_ocp;    // R14
    st_nxt.flags.excite_miss_flags    = st_nxt.flags.excite_miss_flags | set_miss;   // R15
    st_nxt.flags.open_load_flags      = st_nxt.flags.open_load_flags | set_ol;       // R16
    st_nxt.flags.plunger_motion_flags = st_nxt.flags.plunger_motion_flags | set_dpm; // R17
  end

  // state register
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      st_r        <= '0;
      st_r.flags  <= solenoid_regs_pkg::FAULT_RST;
      st_r.rdata  <= solenoid_regs_pkg::RDATA_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o  = st_r.rdata;
  assign reg_rvalid_o = st_r.rvalid;

  // checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_read_clears: assert property (
    rd_fault && fault_evt_i == '0 |=> st_r.flags == '0) // R13
    else $error("fault flags not cleared by read");

  a_read_returns: assert property (
    rd_fault |=> reg_rvalid_o && reg_rdata_o == $past(st_r.flags)) // R13
    else $error("fault read did not return latched flags");

  a_set_wins_clear: assert property (
    rd_fault && fault_evt_i.overcurrent_flags != '0
    |=> st_r.flags.overcurrent_flags == $past(fault_evt_i.overcurrent_flags)) // R14 R20
    else $error("overcurrent event lost or misplaced during clear");

  a_flag_lane: assert property (
    ##1 (st_r.flags.overcurrent_flags & ~$past(st_r.flags.overcurrent_flags)
         & ~$past(fault_evt_i.overcurrent_flags)) == '0) // R20
    else $error("overcurrent flag set in a channel without an event");

  a_excite_cdr_only: assert property (
    ##1 (st_r.flags.excite_miss_flags & ~$past(st_r.flags.excite_miss_flags)
         & ~$past(miss_ok_vec)) == '0) // R19 R12 R15
    else $error("excitation miss flagged without current regulation and enable");

  a_open_load_gate: assert property (
    ##1 (st_r.flags.open_load_flags & ~$past(st_r.flags.open_load_flags)
         & ~$past(open_load_check_en_vec)) == '0) // R10 R16
    else $error("open load flagged while its check is disabled");

  a_plunger_gate: assert property (
    ##1 (st_r.flags.plunger_motion_flags & ~$past(st_r.flags.plunger_motion_flags)
         & ~$past(plunger_check_en_vec)) == '0) // R11 R17
    else $error("plunger fault flagged while its check is disabled");

  a_cfg_readback: assert property (
    reg_wr_i && in_cfg && !reg_rd_i
    ##1 reg_rd_i && !reg_wr_i && reg_addr_i == $past(reg_addr_i)
    |=> reg_rvalid_o && reg_rdata_o == $past(reg_wdata_i, 2)) // R18
    else $error("setup word readback differs from written value");

  a_lowside_current: assert property (
    ##1 ($past(cur_vec) & hi_vec) == '0) // R7
    else $error("high side selected under current regulation");

  a_half_scale_pass: assert property (
    ##1 drive_o[0].half_scale == $past(st_r.cfg[0].half_scale_sel)) // R1
    else $error("half scale selection not passed to channel 0");

  c_fault_read_hit: cover property (rd_fault && st_r.flags != '0);
  c_cfg_write: cover property (reg_wr_i && in_cfg);
  c_excite_phase: cover property (drive_o[0].excite_phase ##1 !drive_o[0].excite_phase);
  c_trigger_drive: cover property (st_r.cfg[0].activation_source_sel && drive_o[0].active);

endmodule // solenoid_channel_config_fault_regs

// [hw/solenoid_regs_pkg.sv]
// package: register map, field layouts and drive types of the solenoid channel register bank
package solenoid_regs_pkg;

  // register addresses
  localparam int unsigned ADDR_W         = 4;
  localparam logic [3:0]  ADDR_CFG_FIRST = 4'h1;
  localparam logic [3:0]  ADDR_CFG_LAST  = 4'h8;
  localparam logic [3:0]  ADDR_FAULT     = 4'h9;

  // reset values
  localparam logic [31:0] CFG_RST        = 32'h0000_0000;
  localparam logic [31:0] FAULT_RST      = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

  // setup word field positions (lsb of each field)
  localparam int unsigned CFG_HALF_SCALE_POS = 31;
  localparam int unsigned CFG_HOLD_POS       = 24;
  localparam int unsigned CFG_ACT_SRC_POS    = 23;
  localparam int unsigned CFG_HIT_POS        = 16;
  localparam int unsigned CFG_HIT_T_POS      = 8;
  localparam int unsigned CFG_REG_METHOD_POS = 7;
  localparam int unsigned CFG_SIDE_POS       = 6;
  localparam int unsigned CFG_CHOP_DIV_POS   = 4;
  localparam int unsigned CFG_SLEW_POS       = 3;
  localparam int unsigned CFG_OPEN_LOAD_CHECK_EN_POS      = 2;
  localparam int unsigned CFG_PLUNGER_EN_POS = 1;
  localparam int unsigned CFG_EXCITE_EN_POS  = 0;

  // fault register field positions
  localparam int unsigned FLT_OVERCURRENT_POS = 24;
  localparam int unsigned FLT_EXCITE_MISS_POS = 16;
  localparam int unsigned FLT_OPEN_LOAD_POS   = 8;
  localparam int unsigned FLT_PLUNGER_POS     = 0;

  // level and excitation-time codes
  localparam logic [6:0] LEVEL_OFF         = 7'h00;
  localparam logic [6:0] LEVEL_FULL        = 7'h7f;
  localparam logic [7:0] HIT_T_NONE        = 8'h00;
  localparam logic [7:0] HIT_T_CONT        = 8'hff;
  localparam logic [5:0] CHOP_PER_UNIT     = 6'h28; // chopping periods per excitation unit
  localparam logic [1:0] CHOP_DIV_MAX_TERM = 2'h3;  // terminal count for divide by four

  // one channel setup word, bit 31 first
  typedef struct packed {
    logic       half_scale_sel;
    logic [6:0] hold_level;
    logic       activation_source_sel;
    logic [6:0] excite_level;
    logic [7:0] excite_time;
    logic       regulation_method_sel;
    logic       side_sel;
    logic [1:0] chop_divider_sel;
    logic       slew_limit_en;
    logic       open_load_check_en;
    logic       plunger_check_en;
    logic       excite_check_en;
  } cfg_t;

  // fault flags (and raw fault events), one bit per channel in each field
  typedef struct packed {
    logic [7:0] overcurrent_flags;
    logic [7:0] excite_miss_flags;
    logic [7:0] open_load_flags;
    logic [7:0] plunger_motion_flags;
  } fault_t;

  // per-channel drive and diagnostic controls towards the output stage
  typedef struct packed {
    logic       active;
    logic       excite_phase;
    logic       high_side;
    logic       hs_gate;
    logic       ls_gate;
    logic       reg_en;
    logic [6:0] level;
    logic       half_scale;
    logic       current_reg;
    logic       slew_en;
    logic       chop_tick;
    logic       ol_run;
    logic       plunger_run;
    logic       excite_chk_run;
  } drive_t;

endpackage

// [verif/host_access_model.sv]
// host-side model of the register access port with write and read cycles
`timescale 1ns/1ps
module host_access_model (
  // clock
  input  wire logic        sys_clk_i,
  // register port towards the device
  output logic [3:0]       reg_addr_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic [31:0]      reg_wdata_o,
  input  wire logic [31:0] reg_rdata_i,
  input  wire logic        reg_rvalid_i
);
  // idle port: strobes low
  initial
  begin
    reg_addr_o  = 4'h0;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 32'h0000_0000;
  end

  // one write strobe; address and data are scrambled once released
  task automatic wr_reg(input logic [3:0] addr, input logic [31:0] data);
    @(posedge sys_clk_i);
    #1;
    reg_addr_o  = addr;
    reg_wdata_o = data;
    reg_wr_o    = 1'b1;
    @(posedge sys_clk_i);
    #1;
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~addr;
    reg_wdata_o = ~data;
  endtask

  // write strobe followed on the very next cycle by a read of the same word
  task automatic wr_rd_reg(input logic [3:0] addr, input logic [31:0] wdata,
                           output logic [31:0] data, output logic ok);
    @(posedge sys_clk_i);
    #1;
    reg_addr_o  = addr;
    reg_wdata_o = wdata;
    reg_wr_o    = 1'b1;
    @(posedge sys_clk_i);
    #1;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b1;
    @(posedge sys_clk_i);
    #1;
    reg_rd_o    = 1'b0;
    reg_addr_o  = ~addr;
    reg_wdata_o = ~wdata;
    ok          = (reg_rvalid_i === 1'b1);
    data        = reg_rdata_i;
  endtask

  // one read strobe; data is taken in the cycle the valid pulse stands
  task automatic rd_reg(input logic [3:0] addr, output logic [31:0] data, output logic ok);
    int n;
    @(posedge sys_clk_i);
    #1;
    reg_addr_o = addr;
    reg_rd_o   = 1'b1;
    @(posedge sys_clk_i);
    #1;
    reg_rd_o   = 1'b0;
    reg_addr_o = ~addr;
    ok         = 1'b0;
    data       = 32'h0000_0000;
    for (n = 0; n < 4 && !ok; n++)
    begin
      if (reg_rvalid_i === 1'b1)
      begin
        ok   = 1'b1;
        data = reg_rdata_i;
      end
      else
      begin
        @(posedge sys_clk_i);
        #1;
      end
    end
  endtask
endmodule // host_access_model

// [verif/solenoid_channel_config_fault_regs_tb.sv]
// self-checking bench for the channel setup and fault flag register bank
`timescale 1ns/1ps
module solenoid_channel_config_fault_regs_tb;
  logic                              sys_clk_i;
  logic                              nrst_i;
  logic [3:0]                        reg_addr;
  logic                              reg_wr;
  logic                              reg_rd;
  logic [31:0]                       reg_wdata;
  logic [31:0]                       reg_rdata;
  logic                              reg_rvalid;
  logic [7:0]                        on_bits;
  logic [7:0]                        external_trigger_pin;
  logic                              base_tick;
  solenoid_regs_pkg::fault_t         fault_evt;
  solenoid_regs_pkg::drive_t [7:0]   drv;
  int                                mismatches;
  int                                check_count;

  // device and host model
  solenoid_channel_config_fault_regs #(.NUM_CH(8)) u_solenoid_channel_config_fault_regs (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .reg_rvalid_o(reg_rvalid), .serial_channel_on_bit_i(on_bits),
    .external_trigger_pin_i(external_trigger_pin), .base_chop_tick_i(base_tick), .fault_evt_i(fault_evt),
    .drive_o(drv));
  host_access_model u_host_access_model (
    .sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid));

  // clock and base chopping tick on every second cycle
  always #4 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) base_tick <= #1 ~base_tick;

  task automatic end_sim();
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic rd_chk(input logic [3:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    logic        ok;
    u_host_access_model.rd_reg(addr, d, ok);
    check("read valid", {31'h0, ok}, 32'h1);
    check("read data", d, exp);
  endtask

  // one-cycle fault event burst
  task automatic pulse(input logic [31:0] v);
    cyc(1);
    fault_evt = v;
    cyc(1);
    fault_evt = 32'h0000_0000;
  endtask

  // channel 0 drive fields packed for one compare
  function automatic logic [31:0] sig(input solenoid_regs_pkg::drive_t d);
    return {13'h0, d.active, d.excite_phase, d.high_side, d.hs_gate, d.ls_gate, d.reg_en,
            d.level, d.half_scale, d.current_reg, d.slew_en, d.ol_run, d.plunger_run,
            d.excite_chk_run};
  endfunction

  task automatic drv_chk(input logic [31:0] cfg, input logic [31:0] exp);
    u_host_access_model.wr_reg(4'h1, cfg);
    on_bits = 8'h01;
    cyc(3);
    check("drive ch0", sig(drv[0]), exp);
  endtask

  // hang guard
  initial
  begin
    repeat (30000) @(posedge sys_clk_i);
    mismatches++;
    end_sim();
  end

  // main sequence
  initial
  begin
    int a;
    int k;
    int cyc_n;
    int ticks;
    logic [31:0] d;
    logic        ok;
    sys_clk_i   = 1'b0;
    nrst_i      = 1'b0;
    on_bits     = 8'h00;
    external_trigger_pin        = 8'h00;
    base_tick   = 1'b0;
    fault_evt   = 32'h0000_0000;
    mismatches  = 0;
    check_count = 0;
    cyc(20);
    nrst_i = 1'b1;
    // reset values of every mapped word
    for (a = 1; a <= 9; a++)
      rd_chk(4'(a), 32'h0000_0000);
    // distinct words per channel, then unmapped and read-clear places
    for (a = 0; a < 8; a++)
      u_host_access_model.wr_reg(4'(a + 1), 32'h1357_9bdf ^ (32'h1111_1111 * a));
    u_host_access_model.wr_reg(4'h0, 32'hffff_ffff);
    u_host_access_model.wr_reg(4'ha, 32'hffff_ffff);
    u_host_access_model.wr_reg(4'h9, 32'hffff_ffff);
    for (a = 0; a < 8; a++)
      rd_chk(4'(a + 1), 32'h1357_9bdf ^ (32'h1111_1111 * a));
    rd_chk(4'h0, 32'h0000_0000);
    rd_chk(4'ha, 32'h0000_0000);
    rd_chk(4'h9, 32'h0000_0000);
    // written word visible to a read on the following cycle
    u_host_access_model.wr_rd_reg(4'h8, 32'h5a5a_a5a5, d, ok);
    check("back-to-back valid", {31'h0, ok}, 32'h1);
    check("back-to-back data", d, 32'h5a5a_a5a5);
    // static field decode on an active channel
    u_host_access_model.wr_reg(4'h1, 32'h0000_0000);
    drv_chk(32'hff00_00fc, {13'h0, 6'b101100, 7'h7f, 6'b100100});
    drv_chk(32'h0000_0048, {13'h0, 6'b100100, 7'h00, 6'b011000});
    drv_chk(32'h4000_00b0, {13'h0, 6'b100001, 7'h40, 6'b000000});
    // activation source
    drv_chk(32'hff80_00fc, {13'h0, 6'b001010, 7'h7f, 6'b100100});
    external_trigger_pin = 8'h01;
    cyc(3);
    check("trigger active", {31'h0, drv[0].active}, 32'h1);
    external_trigger_pin    = 8'h00;
    on_bits = 8'h00;
    // excitation length per chopping divider
    for (a = 0; a < 4; a++)
    begin
      u_host_access_model.wr_reg(4'h1, {8'h10, 8'h20, 8'h01, 2'b10, 2'(a), 4'h0});
      cyc(2);
      on_bits = 8'h01;
      cyc(1);
      cyc_n = 0;
      ticks = 0;
      for (k = 0; k < 1000 && drv[0].excite_phase === 1'b1; k++)
      begin
        cyc_n++;
        if (drv[0].chop_tick === 1'b1)
          ticks++;
        cyc(1);
      end
      k = 4 - a;
      check("excite cycles", {31'h0, cyc_n inside {[80*k-2*k-2:80*k+2*k+2]}}, 32'h1);
      check("excite chops", {31'h0, ticks inside {[39:41]}}, 32'h1);
      check("hold phase", {drv[0].active, drv[0].excite_phase}, 32'h2);
      on_bits = 8'h00;
      cyc(2);
      check("released", {31'h0, drv[0].active}, 32'h0);
    end
    // continuous excitation at full level with plunger and excitation checks running
    u_host_access_model.wr_reg(4'h1, 32'h007f_ff33);
    cyc(300);
    drv_chk(32'h007f_ff33, {13'h0, 6'b110010, 7'h7f, 6'b010011});
    cyc(400);
    check("continuous excite", {31'h0, drv[0].excite_phase}, 32'h1);
    on_bits = 8'h00;
    // per-channel flags, cleared by the read
    for (a = 0; a < 8; a++)
    begin
      u_host_access_model.wr_reg(4'(a + 1), 32'h0000_0007);
      pulse(32'h0101_0101 << a);
      rd_chk(4'h9, 32'h0101_0101 << a);
      rd_chk(4'h9, 32'h0000_0000);
    end
    // gating by regulation method and check enables
    u_host_access_model.wr_reg(4'h6, 32'h0000_0087);
    pulse(32'h2020_2020);
    rd_chk(4'h9, 32'h2000_2020);
    u_host_access_model.wr_reg(4'h6, 32'h0000_0000);
    pulse(32'h2020_2020);
    rd_chk(4'h9, 32'h2000_0000);
    end_sim();
  end
endmodule // solenoid_channel_config_fault_regs_tb
